// ### hdl/two_wire_serial_eeprom_slave.sv
`timescale 1ns/1ps
// Notes on behaviour
// - sample data on clock rise, change output after clock fall.
// - data line is only pulled low or released, never driven high.
// - 1K and 2K sizes compare all three strap inputs.
// - 4K size compares only the high and mid straps.
// - 8K size compares only the high strap.
// - write protect low allows normal reads and writes.
// - write protect high guards the whole array.
// - 1K holds 16 pages of 8 bytes, 7-bit address.
// - 2K holds 32 pages of 8 bytes, 8-bit address.
// - 4K holds 32 pages of 16 bytes, 9-bit address.
// - 8K holds 64 pages of 16 bytes, 10-bit address.
// - data falling with clock high is a start; commands begin so.
// - data rising with clock high is a stop ending the transaction.
// - stop after a read returns the device to standby.
// - every 8-bit word is acknowledged low on the ninth clock, except a select word that does not match.
// - standby at power-up and after stop once writes finish.
// - start, nine clocks, start, stop leaves device ready.
// - internal write finishes within 5 ms of the stop.
// - page writes of 8 or 16 bytes, partial pages allowed.
// - select word is tag, strap or page bits, direction bit.
// - direction high starts a read, low starts a write.
// - page write increments low bits only, wrapping in page.
// - inputs ignored and no acknowledge during internal write.

`include "eeprom_defs.svh"

module two_wire_serial_eeprom_slave
    import eeprom_pkg::*;
#(
    parameter mem_size_t MEM_SIZE    = SIZE_8K,
    parameter int        PROG_CYCLES = `EE_PROG_CYCLES
) (
    input  wire logic clk_i,                    // 40 MHz clock
    input  wire logic sys_rst_i,                // async reset, high
    input  wire logic scl_i,                    // serial clock pin
    input  wire logic sda_i,                    // serial data level
    output logic      sda_o,                    // data drive, always 0
    output logic      sda_oe_n_o,               // low pulls line low
    input  wire logic chip_select_strap_high_i, // strap, high bit
    input  wire logic chip_select_strap_mid_i,  // strap, middle bit
    input  wire logic chip_select_strap_low_i,  // strap, low bit
    input  wire logic write_protect_i,          // high guards array
    output logic      standby_o,                // idle and not writing
    output logic      write_busy_o              // internal write runs
);

    // ************************************************************
    // pin synchronisers and edge detection
    // ************************************************************
    logic [5:0] pins_s;
    link_t      lnk;
    link_t      lnk_q;
    logic       strap_h;
    logic       strap_m;
    logic       strap_l;
    logic       wp_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;

    sync_2ff #(
        .WIDTH   (6),
        .RST_VAL (`EE_PIN_RST)
    ) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({scl_i, sda_i, chip_select_strap_high_i,
                     chip_select_strap_mid_i, chip_select_strap_low_i,
                     write_protect_i}),
        .sync_o    (pins_s)
    );

    assign lnk.scl = pins_s[5];
    assign lnk.sda = pins_s[4];
    assign strap_h = pins_s[3];
    assign strap_m = pins_s[2];
    assign strap_l = pins_s[1];
    assign wp_s    = pins_s[0];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lnk_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            lnk_q <= lnk;
        end
    end

    assign scl_rise = lnk.scl & ~lnk_q.scl;
    assign scl_fall = ~lnk.scl & lnk_q.scl;
    assign start_ev = lnk.scl & lnk_q.scl & lnk_q.sda & ~lnk.sda;
    assign stop_ev  = lnk.scl & lnk_q.scl & ~lnk_q.sda & lnk.sda;

    // ************************************************************
    // size dependent geometry and select compare
    // ************************************************************
    logic [7:0] shift_r;
    logic [7:0] rx_byte;
    logic [9:0] addr_r;
    logic [9:0] addr_mask;
    logic [3:0] page_mask;
    logic [9:0] page_mask10;
    logic       sel_match;
    logic [1:0] sel_hi;

    // the byte as it stands at the eighth rise, before registering
    assign rx_byte = {shift_r[6:0], lnk.sda};

    always_comb begin
        addr_mask = `EE_ADDR_MASK_8K;
        page_mask = `EE_PAGE_MASK_16;
        sel_match = 1'b0;
        sel_hi    = addr_r[9:8];
        unique case (MEM_SIZE)
            SIZE_1K: begin
                // 16 pages of 8, 7-bit address
                addr_mask = `EE_ADDR_MASK_1K;
                page_mask = `EE_PAGE_MASK_8;
                sel_match = (rx_byte[3:1] == {strap_h, strap_m, strap_l});
            end
            SIZE_2K: begin
                // 32 pages of 8, 8-bit address
                addr_mask = `EE_ADDR_MASK_2K;
                page_mask = `EE_PAGE_MASK_8;
                sel_match = (rx_byte[3:1] == {strap_h, strap_m, strap_l});
            end
            SIZE_4K: begin
                // 32 pages of 16, 9-bit address
                addr_mask = `EE_ADDR_MASK_4K;
                page_mask = `EE_PAGE_MASK_16;
                // low strap ignored, bit 1 is a page bit
                sel_match = (rx_byte[3:2] == {strap_h, strap_m});
                sel_hi    = {addr_r[9], rx_byte[1]};
            end
            SIZE_8K: begin
                // 64 pages of 16, 10-bit address
                addr_mask = `EE_ADDR_MASK_8K;
                page_mask = `EE_PAGE_MASK_16;
                // only the high strap, two page bits
                sel_match = (rx_byte[3] == strap_h);
                sel_hi    = rx_byte[2:1];
            end
        endcase
    end

    assign page_mask10 = {6'h00, page_mask};

    // ************************************************************
    // memory array, page buffer and write timer
    // ************************************************************
    logic [7:0]  mem [0:`EE_MEM_WORDS-1];
    logic [7:0]  page_buf [0:`EE_PAGE_MAX-1];
    logic [7:0]  mem_rd;
    logic        pb_we;
    logic [3:0]  pb_idx;
    logic        commit;
    logic        busy;
    logic [15:0] vld_r;
    logic [15:0] vld_nxt;

    assign mem_rd = mem[addr_r];

    // bytes wait here so that an aborted transaction stores nothing
    always_ff @(posedge clk_i) begin
        if (pb_we) begin
            page_buf[pb_idx] <= rx_byte;
        end
    end

    // the array itself is not reset: it models non-volatile content
    always_ff @(posedge clk_i) begin
        if (commit) begin
            // only the bytes received are stored
            for (int i = 0; i < `EE_PAGE_MAX; i++) begin
                if (vld_r[i]) begin
                    mem[(addr_r & ~page_mask10) | 10'(i)] <= page_buf[i];
                end
            end
        end
    end

    program_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (commit),
        .busy_o    (busy)
    );

    // ************************************************************
    // protocol engine
    // ************************************************************
    state_t     state_r;
    state_t     state_nxt;
    phase_t     phase_r;
    phase_t     phase_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [7:0] shift_nxt;
    logic [9:0] addr_nxt;
    logic       oe_n_r;
    logic       oe_n_nxt;
    logic       rd_r;
    logic       rd_nxt;
    logic       wr_pend_r;
    logic       wr_pend_nxt;
    logic       standby_r;
    logic       standby_nxt;

    always_comb begin
        state_nxt   = state_r;
        phase_nxt   = phase_r;
        cnt_nxt     = cnt_r;
        shift_nxt   = shift_r;
        addr_nxt    = addr_r;
        oe_n_nxt    = oe_n_r;
        rd_nxt      = rd_r;
        wr_pend_nxt = wr_pend_r;
        vld_nxt     = vld_r;
        pb_we       = 1'b0;
        pb_idx      = addr_r[3:0] & page_mask;
        commit      = 1'b0;
        if (busy) begin
            // deaf while the internal write runs
            state_nxt = S_IDLE;
            oe_n_nxt  = 1'b1;
        end else if (start_ev) begin
            // any start resynchronises a stuck frame
            // a start abandons any byte in progress
            state_nxt   = S_RX;
            phase_nxt   = PH_SEL;
            cnt_nxt     = 3'h0;
            oe_n_nxt    = 1'b1;
            wr_pend_nxt = 1'b0;
            vld_nxt     = 16'h0000;
        end else if (stop_ev) begin
            // stop ends the transaction and returns to idle
            state_nxt   = S_IDLE;
            oe_n_nxt    = 1'b1;
            wr_pend_nxt = 1'b0;
            vld_nxt     = 16'h0000;
            // protected array never starts a write
            // bytes were acknowledged but are dropped here
            if (wr_pend_r && (vld_r != 16'h0000) && !wp_s) begin
                commit = 1'b1;
            end
        end else begin
            unique case (state_r)
                S_IDLE: begin
                end
                S_RX: begin
                    if (scl_rise) begin
                        shift_nxt = rx_byte;
                        cnt_nxt   = cnt_r + 3'h1;
                        if (cnt_r == `EE_BIT_LAST) begin
                            state_nxt = S_ACK_PEND;
                            unique case (phase_r)
                                PH_SEL: begin
                                    if ((rx_byte[`EE_SEL_TAG_HI:
                                                 `EE_SEL_TAG_LO]
                                         == `EE_SEL_TAG) && sel_match) begin
                                        rd_nxt   = rx_byte[`EE_SEL_DIR_BIT];
                                        addr_nxt = {sel_hi, addr_r[7:0]}
                                                   & addr_mask;
                                    end else begin
                                        // mismatch: no ack, back to standby
                                        state_nxt = S_IDLE;
                                    end
                                end
                                PH_ADDR: begin
                                    // upper bits stay as the select loaded
                                    addr_nxt = {addr_r[9:8], rx_byte}
                                               & addr_mask;
                                end
                                PH_DATA: begin
                                    pb_we               = 1'b1;
                                    vld_nxt[pb_idx]     = 1'b1;
                                    wr_pend_nxt         = 1'b1;
                                    addr_nxt = (addr_r & ~page_mask10)
                                        | ((addr_r + 10'h001) & page_mask10);
                                end
                                default: begin
                                    state_nxt = S_IDLE;
                                end
                            endcase
                        end
                    end
                end
                S_ACK_PEND: begin
                    if (scl_fall) begin
                        // pull low for the ninth clock
                        oe_n_nxt  = 1'b0;
                        state_nxt = S_ACK;
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        oe_n_nxt = 1'b1;
                        cnt_nxt  = 3'h0;
                        if (phase_r == PH_SEL && rd_r) begin
                            // first bit after the falling edge
                            shift_nxt = mem_rd;
                            oe_n_nxt  = mem_rd[7];
                            addr_nxt  = (addr_r + 10'h001) & addr_mask;
                            state_nxt = S_TX;
                        end else begin
                            phase_nxt = (phase_r == PH_SEL) ? PH_ADDR
                                                            : PH_DATA;
                            state_nxt = S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 3'h1;
                        if (cnt_r == `EE_BIT_LAST) begin
                            state_nxt = S_TX_END;
                        end
                    end else if (scl_fall) begin
                        // a one is sent by releasing the line
                        shift_nxt = {shift_r[6:0], 1'b0};
                        oe_n_nxt  = shift_r[6];
                    end
                end
                S_TX_END: begin
                    if (scl_fall) begin
                        // controller owns the ninth bit
                        oe_n_nxt  = 1'b1;
                        state_nxt = S_MACK;
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        // no ack from the controller ends the read
                        state_nxt = lnk.sda ? S_IDLE : S_TX_LOAD;
                    end
                end
                S_TX_LOAD: begin
                    if (scl_fall) begin
                        // reads roll over the whole array
                        shift_nxt = mem_rd;
                        oe_n_nxt  = mem_rd[7];
                        addr_nxt  = (addr_r + 10'h001) & addr_mask;
                        cnt_nxt   = 3'h0;
                        state_nxt = S_TX;
                    end
                end
            endcase
        end
        // standby when idle and no write is pending
        standby_nxt = (state_nxt == S_IDLE) && !commit && !busy;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r   <= S_IDLE;
            phase_r   <= PH_SEL;
            cnt_r     <= 3'h0;
            shift_r   <= 8'h00;
            addr_r    <= `EE_ADDR_RST;
            oe_n_r    <= 1'b1;
            rd_r      <= 1'b0;
            wr_pend_r <= 1'b0;
            vld_r     <= 16'h0000;
            standby_r <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            phase_r   <= phase_nxt;
            cnt_r     <= cnt_nxt;
            shift_r   <= shift_nxt;
            addr_r    <= addr_nxt;
            oe_n_r    <= oe_n_nxt;
            rd_r      <= rd_nxt;
            wr_pend_r <= wr_pend_nxt;
            vld_r     <= vld_nxt;
            standby_r <= standby_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // open drain, the driven level is always low
    assign sda_o        = 1'b0;
    assign sda_oe_n_o   = oe_n_r;
    assign standby_o    = standby_r;
    assign write_busy_o = busy;

endmodule // two_wire_serial_eeprom_slave

// ### hdl/eeprom_defs.svh
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

// ****************************************************************
// select word layout
// ****************************************************************
`define EE_SEL_TAG        4'hA
`define EE_SEL_TAG_HI     7
`define EE_SEL_TAG_LO     4
`define EE_SEL_DIR_BIT    0

// ****************************************************************
// memory geometry
// ****************************************************************
`define EE_MEM_WORDS      1024
`define EE_PAGE_MAX       16
`define EE_ADDR_MASK_1K   10'h07F
`define EE_ADDR_MASK_2K   10'h0FF
`define EE_ADDR_MASK_4K   10'h1FF
`define EE_ADDR_MASK_8K   10'h3FF
`define EE_PAGE_MASK_8    4'h7
`define EE_PAGE_MASK_16   4'hF

// ****************************************************************
// bit counting and reset values
// ****************************************************************
`define EE_BIT_LAST       3'h7
`define EE_PIN_RST        6'h3F
`define EE_ADDR_RST       10'h000

// ****************************************************************
// timing
// ****************************************************************
`define EE_PROG_TIME_US   5000
`define EE_CLK_FREQ_MHZ   40
`define EE_PROG_CYCLES    (`EE_PROG_TIME_US * `EE_CLK_FREQ_MHZ)

`endif

// ### hdl/eeprom_pkg.sv
package eeprom_pkg;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        SIZE_1K,
        SIZE_2K,
        SIZE_4K,
        SIZE_8K
    } mem_size_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_RX,
        S_ACK_PEND,
        S_ACK,
        S_TX,
        S_TX_END,
        S_MACK,
        S_TX_LOAD
    } state_t;

    typedef enum logic [1:0] {
        PH_SEL,
        PH_ADDR,
        PH_DATA
    } phase_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } link_t;

endpackage

// ### hdl/sync_2ff.sv
`timescale 1ns/1ps

module sync_2ff #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_i,     // system clock
    input  wire logic             sys_rst_i, // async reset, high
    input  wire logic [WIDTH-1:0] async_i,   // pins from outside
    output logic      [WIDTH-1:0] sync_o     // synchronised copy
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule // sync_2ff

// ### hdl/program_timer.sv
`timescale 1ns/1ps

module program_timer #(
    parameter int CYCLES = 1
) (
    input  wire logic clk_i,     // system clock
    input  wire logic sys_rst_i, // async reset, high
    input  wire logic start_i,   // one-cycle start pulse
    output logic      busy_o     // high while cycle runs
);

    logic [17:0] cnt_r;
    logic [17:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (start_i) begin
            cnt_nxt = 18'(CYCLES);
        end else if (cnt_r != 18'h0_0000) begin
            cnt_nxt = cnt_r - 18'h0_0001;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= 18'h0_0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign busy_o = (cnt_r != 18'h0_0000);

endmodule // program_timer

// ### tb/eeprom_checker.sv
`timescale 1ns/1ps
// ******************
// link port checks
// ******************
module eeprom_checker
    import eeprom_pkg::*;
#(
    parameter int PROG_CYCLES = 1
) (
    input  wire logic clk_i,                    // clock
    input  wire logic sys_rst_i,                // reset
    input  wire logic scl_i,                    // clock pin
    input  wire logic sda_i,                    // data wire
    input  wire logic sda_o,                    // drive
    input  wire logic sda_oe_n_o,               // pull
    input  wire logic chip_select_strap_high_i, // strap
    input  wire logic chip_select_strap_mid_i,  // strap
    input  wire logic chip_select_strap_low_i,  // strap
    input  wire logic write_protect_i,          // guard
    input  wire logic standby_o,                // idle
    input  wire logic write_busy_o              // busy
);
    logic [31:0] busy_cnt_r;
    logic [31:0] busy_cnt_nxt;

    // counts busy cycles so the program time is judged exactly
    always_comb begin
        busy_cnt_nxt = write_busy_o ? busy_cnt_r + 32'h0000_0001 : '0;
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_cnt_r <= '0;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_drive_zero: assert property (sda_o == 1'b0)
        else $error("drive value not zero");
    a_busy_no_ack: assert property (write_busy_o |-> sda_oe_n_o)
        else $error("pull during write cycle");
    a_busy_awake: assert property (write_busy_o |-> !standby_o)
        else $error("standby during write cycle");
    a_out_after_fall: assert property (
        $changed(sda_oe_n_o) |-> !$past(scl_i, 2))
        else $error("data out moved with clock high");
    a_prog_time: assert property (
        $fell(write_busy_o) |-> busy_cnt_r == PROG_CYCLES)
        else $error("write cycle length wrong");
    a_write_at_stop: assert property (
        $rose(write_busy_o) |-> scl_i && sda_i && !write_protect_i)
        else $error("write cycle without stop or when guarded");
    a_ack_awake: assert property (!sda_oe_n_o |-> !standby_o)
        else $error("pull in standby");
    a_leave_standby: assert property (
        $fell(standby_o) |-> write_busy_o || !sda_i || !scl_i)
        else $error("left standby without start");
endmodule // eeprom_checker

// ### tb/bus_ctl.sv
`timescale 1ns/1ps
// ******************
// bus controller
// ******************
module bus_ctl (
    input  wire logic clk_i,      // bench clock
    input  wire logic sda_i,      // data wire
    output logic      scl_o,      // clock, idles high
    output logic      sda_oe_n_o  // low pulls data
);
    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic bit_x(input logic b, output logic r);
        scl_o <= 1'b0;
        tick(1);
        sda_oe_n_o <= b;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        r = sda_i;
    endtask
    task automatic start();
        logic r;
        bit_x(1'b1, r);
        sda_oe_n_o <= 1'b0;
        tick(4);
    endtask
    task automatic stop();
        logic r;
        bit_x(1'b0, r);
        sda_oe_n_o <= 1'b1;
        tick(4);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, nack);
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(last, r);
    endtask
    task automatic recover();
        logic r;
        start();
        repeat (9) bit_x(1'b1, r);
        start();
        stop();
    endtask
endmodule // bus_ctl

// ### tb/tb.sv
`timescale 1ns/1ps
// ******************
// bench
// ******************
module tb
    import eeprom_pkg::*;
;
    localparam int PROG = 200;
    logic clk_i, sys_rst_i, scl_i, sda_i, sda_o, sda_oe_n_o, ctl_oe_n;
    logic chip_select_strap_high_i, chip_select_strap_mid_i;
    logic chip_select_strap_low_i, write_protect_i, standby_o;
    logic        write_busy_o;
    logic [7:0]  mem_m [1024];
    logic [31:0] seed = 32'h0000_000C;
    int          n_fail, checked, cyc;

    // pull-up on the data wire
    assign sda_i = sda_oe_n_o & ctl_oe_n;

    two_wire_serial_eeprom_slave #(
        .MEM_SIZE(SIZE_8K),
        .PROG_CYCLES(PROG)
    ) two_wire_serial_eeprom_slave_i (
        .clk_i, .sys_rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o,
        .chip_select_strap_high_i, .chip_select_strap_mid_i,
        .chip_select_strap_low_i, .write_protect_i, .standby_o,
        .write_busy_o
    );
    bus_ctl bus_ctl_i (.clk_i, .sda_i, .scl_o(scl_i), .sda_oe_n_o(ctl_oe_n));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] sel(logic [9:0] a, logic rd);
        return {4'hA, 1'b1, a[9:8], rd};
    endfunction
    task automatic chk_byte(string name, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(string name, logic exp, logic got);
        chk_byte(name, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic finish_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic addr_phase(logic [9:0] a);
        logic nack;
        bus_ctl_i.start();
        bus_ctl_i.wbyte(sel(a, 1'b0), nack);
        chk_bit("select ack", 1'b0, nack);
        bus_ctl_i.wbyte(a[7:0], nack);
        chk_bit("address ack", 1'b0, nack);
    endtask
    task automatic wr_seq(logic [9:0] a, int n);
        logic       nack;
        logic [7:0] d;
        logic [3:0] off;
        off = a[3:0];
        addr_phase(a);
        for (int i = 0; i < n; i++) begin
            d = xs();
            bus_ctl_i.wbyte(d, nack);
            chk_bit("data ack", 1'b0, nack);
            // in-page wrap of the low address bits
            if (write_protect_i === 1'b0) begin
                mem_m[{a[9:4], off}] = d;
            end
            off++;
        end
        bus_ctl_i.stop();
        repeat (8) @(posedge clk_i);
        chk_bit("busy", ~write_protect_i, write_busy_o);
        if (write_protect_i === 1'b0) begin
            bus_ctl_i.start();
            bus_ctl_i.wbyte(sel(a, 1'b1), nack);
            chk_bit("poll ack", 1'b1, nack);
            bus_ctl_i.stop();
        end
        for (int k = 0; k < PROG && write_busy_o !== 1'b0; k++) begin
            @(posedge clk_i);
        end
        repeat (3) @(posedge clk_i);
        chk_bit("standby", 1'b1, standby_o);
    endtask
    task automatic rd_seq(logic [9:0] a, int n);
        logic       nack;
        logic [7:0] d;
        addr_phase(a);
        bus_ctl_i.start();
        bus_ctl_i.wbyte(sel(a, 1'b1), nack);
        chk_bit("read select ack", 1'b0, nack);
        for (int i = 0; i < n; i++) begin
            bus_ctl_i.rbyte(i == n - 1, d);
            chk_byte("read data", mem_m[(a + i) % 1024], d);
        end
        bus_ctl_i.stop();
        repeat (4) @(posedge clk_i);
        chk_bit("standby", 1'b1, standby_o);
    endtask
    initial begin
        logic [7:0] r;
        logic       nack;
        sys_rst_i = 1'b1;
        write_protect_i = 1'b0;
        chip_select_strap_high_i = 1'b1;
        chip_select_strap_mid_i = 1'b0;
        chip_select_strap_low_i = 1'b0;
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        wr_seq(10'h1FE, 17);
        rd_seq(10'h1F0, 16);
        write_protect_i <= 1'b1;
        wr_seq(10'h1F0, 2);
        rd_seq(10'h1F0, 2);
        write_protect_i <= 1'b0;
        r = xs();
        chip_select_strap_mid_i <= r[0];
        chip_select_strap_low_i <= r[1];
        for (int i = 0; i < 2; i++) begin
            bus_ctl_i.start();
            bus_ctl_i.wbyte(i ? 8'hE8 : 8'hA0, nack);
            chk_bit("bad select ack", 1'b1, nack);
            bus_ctl_i.stop();
        end
        bus_ctl_i.recover();
        rd_seq(10'h1F4, 3);
        finish_test();
    end
endmodule // tb

bind two_wire_serial_eeprom_slave eeprom_checker #(
    .PROG_CYCLES(PROG_CYCLES)
) eeprom_checker_i (
    .clk_i, .sys_rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o,
    .chip_select_strap_high_i, .chip_select_strap_mid_i,
    .chip_select_strap_low_i, .write_protect_i, .standby_o,
    .write_busy_o
);
